// ---- hw/hpc_cfg.svh ----
// Constants of the host to PCI cycle generator: offsets, encodings, reset values
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH

// Configuration port offsets within PCI I/O space
`define HPC_CFG_PTR_OFS      32'h0000_0CF8
`define HPC_CFG_DAT_OFS      32'h0000_0CFC
// Processor address of the interrupt acknowledge read register
`define HPC_IACK_ADDR        32'hFEFF_0030

// PCI command codes on C/BE during the address phase
`define HPC_CMD_IACK         4'h0
`define HPC_CMD_SPECIAL      4'h1
`define HPC_CMD_IO_RD        4'h2
`define HPC_CMD_IO_WR        4'h3
`define HPC_CMD_MEM_RD       4'h6
`define HPC_CMD_MEM_WR       4'h7
`define HPC_CMD_CFG_RD       4'hA
`define HPC_CMD_CFG_WR       4'hB

// Configuration pointer field positions
`define HPC_PTR_EN_BIT       31
`define HPC_PTR_BUS_HI       23
`define HPC_PTR_BUS_LO       16
`define HPC_PTR_DEV_HI       15
`define HPC_PTR_DEV_LO       11
`define HPC_PTR_FUNC_HI      10
`define HPC_PTR_FUNC_LO      8
`define HPC_PTR_REG_HI       7
`define HPC_PTR_REG_LO       2
// Special cycle encoding: bus 0, device all ones, function all ones, register 0
`define HPC_SPECIAL_PTR      32'h8000_FF00
`define HPC_PTR_RESET        32'h0000_0000

// Device numbers: first that maps to AD11, and the one that maps to AD31
`define HPC_DEV_FIRST_IDSEL  5'h0B
`define HPC_DEV_AD31         5'h00
`define HPC_DEV_NONE         5'h1F
`define HPC_IDSEL_LOW_AD     11

// Window 3 reset values (upper 16 address bits): PCI I/O 0 at 0x80000000
`define HPC_WIN3_START_RST   16'h8000
`define HPC_WIN3_END_RST     16'hBFFF
`define HPC_WIN3_OFS_RST     16'h8000
`define HPC_WIN_IO_INDEX     2'h3

// Little-endian address XOR masks per operand size
`define HPC_LE_XOR_1         3'h7
`define HPC_LE_XOR_2         3'h6
`define HPC_LE_XOR_4         3'h4
`define HPC_LE_XOR_8         3'h0

`endif

// ---- hw/hpc_cycle_gen.sv ----
// Host to PCI cycle generator: windows, configuration port, special and IACK cycles
//
// Summary of operation
// - Window mem and spread bits pick cycle kind
// - Memory select: address plus offset, memory cycle
// - Both clear: contiguous I/O, address plus offset
// - Spread I/O: offset then spread translation
// - Pointer write local; data access makes cycle
// - Bad pointer or width: plain I/O
// - Pointer at CF8, data at CFC
// - Only window 3 reaches I/O configuration
// - Register and function go on low bits
// - Upper twenty-one address lines carry device select
// - Device number decodes to at most one AD line
// - Bus zero Type 0, nonzero Type 1
// - Special pointer then data write: special cycle
// - IACK read: one cycle, its enables, vector
// - Big mode swaps data both directions
// - Little mode XORs low address by size
// - Unaligned PCI transfers split into aligned
`timescale 1ns/1ps
`default_nettype none
`include "hpc_cfg.svh"

module hpc_cycle_gen (
    input  wire logic        MCLK_I,        // Bridge clock
    input  wire logic        RST_N_I,       // Asynchronous reset, low
    input  wire logic        BIG_END_I,     // Big-endian mode
    input  wire logic        WIN_LOAD_I,    // Load one window
    input  wire logic [1:0]  WIN_IDX_I,     // Window to load
    input  wire logic        WIN_EN_I,      // Window enable
    input  wire logic        WIN_MEM_I,     // Memory select
    input  wire logic        WIN_IOM_I,     // io_spread_select
    input  wire logic [15:0] WIN_START_I,   // Window start, upper bits
    input  wire logic [15:0] WIN_STOP_I,    // Window end, upper bits
    input  wire logic [15:0] WIN_OFS_I,     // outbound_window_offset
    input  wire logic        REQ_VALID_I,   // Processor request
    output logic             REQ_READY_O,   // Request accepted
    input  wire logic        REQ_WRITE_I,   // Write when high
    input  wire logic [31:0] REQ_ADDR_I,    // Processor address
    input  wire logic [3:0]  REQ_SIZE_I,    // Bytes: 1, 2, 4, 8
    input  wire logic [63:0] REQ_WDATA_I,   // Write data
    output logic             RSP_VALID_O,   // Answer pulse
    output logic             RSP_MISS_O,    // No window hit
    output logic      [63:0] RSP_RDATA_O,   // Read data
    output logic             PCI_START_O,   // Cycle launch pulse
    output logic      [3:0]  PCI_CMD_O,     // PCI command
    output logic      [31:0] PCI_ADDR_O,    // PCI address phase
    output logic      [7:0]  PCI_BE_O,      // PCI byte enables
    output logic      [63:0] PCI_WDATA_O,   // PCI write data
    input  wire logic        PCI_DONE_I,    // Cycle finished
    input  wire logic [63:0] PCI_RDATA_I,   // PCI read data
    input  wire logic        IN_VALID_I,    // PCI-originated transfer
    output logic             IN_READY_O,    // Transfer taken
    input  wire logic [31:0] IN_ADDR_I,     // Start address
    input  wire logic [3:0]  IN_LEN_I,      // Length in bytes, 1 to 8
    output logic             SPL_VALID_O,   // Aligned piece valid
    input  wire logic        SPL_READY_I,   // Piece taken
    output logic      [31:0] SPL_ADDR_O,    // Piece processor address
    output logic      [3:0]  SPL_SIZE_O     // Piece size in bytes
);

    // =========================================================
    // Functions
    // =========================================================
    // Spread I/O: each 4 KB processor page holds 32 bytes of one device
    function automatic logic [31:0] spread_io(input logic [31:0] a);
        spread_io = {7'h00, a[31:12], a[4:0]};
    endfunction

    // Device number to IDSEL line among AD31..AD11
    function automatic logic [20:0] idsel_of(input logic [4:0] dev);
        idsel_of = 21'h00000;
        if (dev == `HPC_DEV_AD31) begin
            idsel_of[20] = 1'b1;
        end else if (dev >= `HPC_DEV_FIRST_IDSEL && dev != `HPC_DEV_NONE) begin
            idsel_of[dev - `HPC_DEV_FIRST_IDSEL] = 1'b1;
        end
    endfunction

    // Largest aligned piece not beyond the bytes left
    function automatic logic [3:0] piece_of(input logic [2:0] a, input logic [3:0] left);
        if (a == 3'h0 && left >= 4'h8) begin
            piece_of = 4'h8;
        end else if (a[1:0] == 2'h0 && left >= 4'h4) begin
            piece_of = 4'h4;
        end else if (a[0] == 1'b0 && left >= 4'h2) begin
            piece_of = 4'h2;
        end else begin
            piece_of = 4'h1;
        end
    endfunction

    // =========================================================
    // Declarations
    // =========================================================
    hpc_pkg::hpc_win_t   win_q [4];      // Outbound windows
    hpc_pkg::hpc_state_t state_q;        // Sequencer state
    logic [31:0]         ptr_q;          // cfg_target_pointer
    logic [31:0]         e_addr;         // Address after endian unit
    logic [7:0]          e_be;           // Enables after endian unit
    logic [63:0]         e_wdata;        // Write data after endian unit
    logic [63:0]         r_data;         // Read data after endian unit
    logic [7:0]          raw_be;         // Enables from size and address
    logic                hit;            // Some window decodes
    logic [1:0]          hit_idx;        // First hitting window
    logic [31:0]         pci_a;          // Translated PCI address
    logic                io_win3;        // I/O through window 3
    logic                width_ok;       // 1, 2 or 4 bytes
    logic                is_ptr;         // Pointer access
    logic                is_dat;         // Data window access
    logic                ptr_ok;         // Pointer enable set
    logic                is_iack;        // IACK read
    logic [31:0]         ptr_wword;      // Merged pointer write word
    logic [3:0]          cmd_d;          // Command to launch
    logic [31:0]         addr_d;         // Address to launch
    logic                take;           // Request taken this cycle
    logic                local_d;        // Answered without PCI
    logic [63:0]         word_d;         // Local read data

    // =========================================================
    // Window registers
    // =========================================================
    // Window 3 comes up mapping PCI I/O, the others disabled
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < 3; i++) begin
                win_q[i] <= '0;
            end
            win_q[3] <= '{en: 1'b1, mem: 1'b0, io_spread_select: 1'b0, start: `HPC_WIN3_START_RST,
                          stop: `HPC_WIN3_END_RST, ofs: `HPC_WIN3_OFS_RST};
        end else if (WIN_LOAD_I) begin
            win_q[WIN_IDX_I] <= '{en: WIN_EN_I, mem: WIN_MEM_I, io_spread_select: WIN_IOM_I,
                                  start: WIN_START_I, stop: WIN_STOP_I, ofs: WIN_OFS_I};
        end
    end

    // =========================================================
    // Endian conversion, both directions
    // =========================================================
    // Lanes follow processor address before any fix
    assign raw_be = 8'((16'h00FF >> (5'd8 - {1'b0, REQ_SIZE_I})) << REQ_ADDR_I[2:0]);

    hpc_endian u_end_out (
        .big_i  (BIG_END_I),
        .size_i (REQ_SIZE_I),
        .addr_i (REQ_ADDR_I),
        .be_i   (raw_be),
        .data_i (REQ_WDATA_I),
        .addr_o (e_addr),
        .be_o   (e_be),
        .data_o (e_wdata)
    );

    hpc_endian u_end_in (
        .big_i  (BIG_END_I),
        .size_i (REQ_SIZE_I),
        .addr_i (REQ_ADDR_I),
        .be_i   (8'h00),
        .data_i (PCI_RDATA_I),
        .addr_o (),
        .be_o   (),
        .data_o (r_data)
    );

    // =========================================================
    // Decode and translation
    // =========================================================
    // Lowest hitting window wins; its mem and spread bits pick the kind
    always_comb begin
        hit     = 1'b0;
        hit_idx = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (win_q[i].en && e_addr[31:16] >= win_q[i].start
                            && e_addr[31:16] <= win_q[i].stop) begin
                hit     = 1'b1;
                hit_idx = 2'(i);
            end
        end
        pci_a = e_addr + {win_q[hit_idx].ofs, 16'h0000};
        if (!win_q[hit_idx].mem && win_q[hit_idx].io_spread_select) begin
            pci_a = spread_io(pci_a);
        end
    end

    assign is_iack  = !REQ_WRITE_I && REQ_ADDR_I == `HPC_IACK_ADDR;
    assign io_win3  = hit && hit_idx == `HPC_WIN_IO_INDEX && !win_q[hit_idx].mem;
    assign width_ok = REQ_SIZE_I == 4'h1 || REQ_SIZE_I == 4'h2 || REQ_SIZE_I == 4'h4;
    assign is_ptr   = io_win3 && width_ok && {pci_a[31:2], 2'b00} == `HPC_CFG_PTR_OFS;
    assign is_dat   = io_win3 && width_ok && {pci_a[31:2], 2'b00} == `HPC_CFG_DAT_OFS;
    assign ptr_ok   = ptr_q[`HPC_PTR_EN_BIT];

    // Pointer bypasses the endian swap; lanes follow the processor address
    always_comb begin
        ptr_wword = ptr_q;
        for (int b = 0; b < 4; b++) begin
            if (raw_be[{REQ_ADDR_I[2], 2'(b)}]) begin
                ptr_wword[8*b +: 8] = REQ_WDATA_I[{REQ_ADDR_I[2], 2'(b), 3'h0} +: 8];
            end
        end
    end

    // Command and address for the cycle about to launch
    always_comb begin
        cmd_d   = REQ_WRITE_I ? `HPC_CMD_IO_WR : `HPC_CMD_IO_RD;
        addr_d  = pci_a;
        local_d = !hit && !is_iack;
        if (is_iack) begin
            cmd_d = `HPC_CMD_IACK;
        end else if (is_ptr) begin
            local_d = 1'b1;
        end else if (is_dat && ptr_ok) begin
            if (REQ_WRITE_I && ptr_q == `HPC_SPECIAL_PTR) begin
                cmd_d = `HPC_CMD_SPECIAL;
            end else begin
                cmd_d = REQ_WRITE_I ? `HPC_CMD_CFG_WR : `HPC_CMD_CFG_RD;
            end
            if (ptr_q[`HPC_PTR_BUS_HI:`HPC_PTR_BUS_LO] != 8'h00) begin
                addr_d = {8'h00, ptr_q[23:2], 2'b01};
            end else begin
                addr_d = {idsel_of(ptr_q[`HPC_PTR_DEV_HI:`HPC_PTR_DEV_LO]),
                          ptr_q[`HPC_PTR_FUNC_HI:`HPC_PTR_FUNC_LO],
                          ptr_q[`HPC_PTR_REG_HI:`HPC_PTR_REG_LO], 2'b00};
            end
        end else if (win_q[hit_idx].mem) begin
            cmd_d = REQ_WRITE_I ? `HPC_CMD_MEM_WR : `HPC_CMD_MEM_RD;
        end
        word_d = {ptr_q, ptr_q};
    end

    // =========================================================
    // Outbound sequencer
    // =========================================================
    assign REQ_READY_O = state_q == hpc_pkg::HPC_IDLE;
    assign take        = REQ_VALID_I && REQ_READY_O;

    // Idle takes a request; issue waits for done; resp answers
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= hpc_pkg::HPC_IDLE;
        end else begin
            unique case (state_q)
                hpc_pkg::HPC_IDLE: begin
                    if (take) begin
                        state_q <= local_d ? hpc_pkg::HPC_RESP : hpc_pkg::HPC_ISSUE;
                    end
                end
                hpc_pkg::HPC_ISSUE: begin
                    if (PCI_DONE_I) begin
                        state_q <= hpc_pkg::HPC_RESP;
                    end
                end
                hpc_pkg::HPC_RESP: begin
                    state_q <= hpc_pkg::HPC_IDLE;
                end
            endcase
        end
    end

    // Pointer is written locally and never produces a cycle
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ptr_q <= `HPC_PTR_RESET;
        end else if (take && is_ptr && REQ_WRITE_I && !is_iack) begin
            ptr_q <= ptr_wword;
        end
    end

    // Launch registers: one start pulse per non-local request
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PCI_START_O <= 1'b0;
            PCI_CMD_O   <= 4'h0;
            PCI_ADDR_O  <= 32'h0000_0000;
            PCI_BE_O    <= 8'h00;
            PCI_WDATA_O <= 64'h0;
        end else begin
            PCI_START_O <= take && !local_d;
            if (take && !local_d) begin
                PCI_CMD_O   <= cmd_d;
                PCI_ADDR_O  <= addr_d;
                PCI_BE_O    <= e_be;
                PCI_WDATA_O <= e_wdata;
            end
        end
    end

    // Answer: local pointer data, miss, or PCI read data after the endian unit
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RSP_VALID_O <= 1'b0;
            RSP_MISS_O  <= 1'b0;
            RSP_RDATA_O <= 64'h0;
        end else begin
            RSP_VALID_O <= state_q == hpc_pkg::HPC_RESP;
            if (take && local_d) begin
                RSP_MISS_O  <= !hit;
                RSP_RDATA_O <= hit ? word_d : 64'h0;
            end else if (state_q == hpc_pkg::HPC_ISSUE && PCI_DONE_I) begin
                RSP_MISS_O  <= 1'b0;
                RSP_RDATA_O <= r_data;
            end
        end
    end

    // =========================================================
    // Inbound splitter
    // =========================================================
    logic [31:0] in_addr_q;  // Next piece address
    logic [3:0]  in_left_q;  // Bytes still to send
    logic [3:0]  pc;         // Current piece size

    assign pc          = piece_of(in_addr_q[2:0], in_left_q);
    assign SPL_VALID_O = in_left_q != 4'h0;
    assign IN_READY_O  = in_left_q == 4'h0;

    // Pieces carry the little-endian address fix for their own size
    assign SPL_ADDR_O = BIG_END_I ? in_addr_q
                      : {in_addr_q[31:3], in_addr_q[2:0] ^ hpc_pkg::hpc_le_mask(pc)};
    assign SPL_SIZE_O = pc;

    // Walk the transfer in aligned pieces
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            in_addr_q <= 32'h0000_0000;
            in_left_q <= 4'h0;
        end else if (IN_VALID_I && IN_READY_O) begin
            in_addr_q <= IN_ADDR_I;
            in_left_q <= IN_LEN_I;
        end else if (SPL_VALID_O && SPL_READY_I) begin
            in_addr_q <= in_addr_q + {28'h0, pc};
            in_left_q <= in_left_q - pc;
        end
    end

    // =========================================================
    // Assertions
    // =========================================================
    sequence s_ptr_write;
        take && is_ptr && REQ_WRITE_I && !is_iack;
    endsequence
    sequence s_launch;
        take && !local_d;
    endsequence

    a_ptr_no_cycle: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        s_ptr_write |=> !PCI_START_O ##1 RSP_VALID_O) else $error("pointer write launched");
    a_launch_once: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        s_launch |=> PCI_START_O ##1 !PCI_START_O) else $error("launch not single");
    a_iack_cmd: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        take && is_iack |=> PCI_CMD_O == `HPC_CMD_IACK && PCI_BE_O == $past(e_be))
        else $error("iack cycle wrong");
    a_idsel_onehot: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        PCI_START_O && PCI_CMD_O[3:1] == 3'b101 && PCI_ADDR_O[1:0] == 2'b00
        |-> $onehot0(PCI_ADDR_O[31:11])) else $error("idsel not onehot");
    a_type1_addr: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        s_launch ##0 (is_dat && ptr_ok && ptr_q[23:16] != 8'h00)
        |=> PCI_ADDR_O[1:0] == 2'b01) else $error("type1 address");
    a_mem_cmd: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        s_launch ##0 (hit && win_q[hit_idx].mem && !is_iack)
        |=> PCI_CMD_O[3:1] == 3'b011 && PCI_ADDR_O == $past(pci_a))
        else $error("memory cycle wrong");
    a_special_cmd: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        s_launch ##0 (is_dat && REQ_WRITE_I && ptr_q == `HPC_SPECIAL_PTR && !is_iack)
        |=> PCI_CMD_O == `HPC_CMD_SPECIAL) else $error("special cycle missing");
    a_bad_width_io: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        s_launch ##0 (io_win3 && !width_ok && !is_iack)
        |=> PCI_CMD_O[3:1] == 3'b001) else $error("bad width not plain I/O");
    a_split_aligned: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        SPL_VALID_O |-> (in_addr_q[2:0] & 3'(SPL_SIZE_O - 4'h1)) == 3'h0
        && SPL_SIZE_O <= in_left_q) else $error("piece misaligned");
    a_resp_bound: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        take && local_d |-> ##2 RSP_VALID_O) else $error("local answer late");

endmodule

`default_nettype wire

// ---- hw/hpc_endian.sv ----
// Endian unit: big-endian lane reversal or little-endian address fix
`timescale 1ns/1ps
`default_nettype none

module hpc_endian (
    input  wire logic        big_i,   // Big-endian mode
    input  wire logic [3:0]  size_i,  // Operand size in bytes
    input  wire logic [31:0] addr_i,  // Incoming address
    input  wire logic [7:0]  be_i,    // Incoming byte enables
    input  wire logic [63:0] data_i,  // Incoming data
    output logic      [31:0] addr_o,  // Outgoing address
    output logic      [7:0]  be_o,    // Outgoing byte enables
    output logic      [63:0] data_o   // Outgoing data
);

    // =========================================================
    // Lane reversal and address modification
    // =========================================================
    // Big mode swaps all eight lanes and leaves the address; little mode the reverse
    always_comb begin
        addr_o = addr_i;
        be_o   = be_i;
        data_o = data_i;
        if (big_i) begin
            for (int i = 0; i < 8; i++) begin
                data_o[8*i +: 8] = data_i[8*(7-i) +: 8];
                be_o[i]          = be_i[7-i];
            end
        end else begin
            addr_o[2:0] = addr_i[2:0] ^ hpc_pkg::hpc_le_mask(size_i);
        end
    end

endmodule

`default_nettype wire

// ---- hw/hpc_pkg.sv ----
// Types and shared functions of the host to PCI cycle generator
`include "hpc_cfg.svh"

package hpc_pkg;

    // Outbound sequencer states
    typedef enum logic [1:0] {
        HPC_IDLE  = 2'b00,
        HPC_ISSUE = 2'b01,
        HPC_RESP  = 2'b10
    } hpc_state_t;

    // One outbound window
    typedef struct packed {
        logic        en;     // Window decodes
        logic        mem;    // Memory select
        logic        io_spread_select;    // Spread I/O select
        logic [15:0] start;  // First upper address
        logic [15:0] stop;   // Last upper address
        logic [15:0] ofs;    // Upper address offset
    } hpc_win_t;

    // Little-endian address fix for a given operand size in bytes
    function automatic logic [2:0] hpc_le_mask(input logic [3:0] size);
        case (size)
            4'h1:    hpc_le_mask = `HPC_LE_XOR_1;
            4'h2:    hpc_le_mask = `HPC_LE_XOR_2;
            4'h4:    hpc_le_mask = `HPC_LE_XOR_4;
            default: hpc_le_mask = `HPC_LE_XOR_8;
        endcase
    endfunction

endpackage

// ---- verif/hpc_cycle_gen_tb.sv ----
// Bench of the host to PCI cycle generator against a reference model
`timescale 1ns/1ps
`default_nettype none
module hpc_cycle_gen_tb;
    logic        clk = 0, rst_n = 0, big = 0, wl = 0, wm = 0, wi = 0, rv = 0, rw = 0, iv = 0, sr = 0;
    logic [1:0]  wx = 2'h0;
    logic [3:0]  rs = 4'h4, il = 4'h1, pw = 4'h0, pc, ss;
    logic [15:0] wst = 16'h0, wo = 16'h0;
    logic [31:0] ra = 32'h0, ia = 32'h0, x = 32'h53, pa, sa, p, a;
    logic [63:0] rwd = 64'h0, pat = 64'h0, rd, pwd, prd;
    logic        rr, rsv, miss, ps, pd, ir, sv;
    logic [7:0]  pb;
    logic [4:0]  dv [6] = '{5'h00, 5'h0A, 5'h0B, 5'h1E, 5'h1F, 5'h05};
    int          num_errors = 0, comparisons = 0, starts = 0, cyc = 0, l, s;
    hpc_cycle_gen u_dut (.MCLK_I(clk), .RST_N_I(rst_n), .BIG_END_I(big), .WIN_LOAD_I(wl),
        .WIN_IDX_I(wx), .WIN_EN_I(1'b1), .WIN_MEM_I(wm), .WIN_IOM_I(wi), .WIN_START_I(wst),
        .WIN_STOP_I(wst), .WIN_OFS_I(wo), .REQ_VALID_I(rv), .REQ_READY_O(rr), .REQ_WRITE_I(rw),
        .REQ_ADDR_I(ra), .REQ_SIZE_I(rs), .REQ_WDATA_I(rwd), .RSP_VALID_O(rsv), .RSP_MISS_O(miss),
        .RSP_RDATA_O(rd), .PCI_START_O(ps), .PCI_CMD_O(pc), .PCI_ADDR_O(pa), .PCI_BE_O(pb),
        .PCI_WDATA_O(pwd), .PCI_DONE_I(pd), .PCI_RDATA_I(prd), .IN_VALID_I(iv), .IN_READY_O(ir),
        .IN_ADDR_I(ia), .IN_LEN_I(il), .SPL_VALID_O(sv), .SPL_READY_I(sr), .SPL_ADDR_O(sa),
        .SPL_SIZE_O(ss));
    hpc_pci_tgt u_tgt (.clk_i(clk), .rst_n_i(rst_n), .start_i(ps), .wait_i(pw), .pat_i(pat),
        .done_o(pd), .data_o(prd));
    always #10 clk = ~clk;
    // Count launches and cut a hang short
    always @(posedge clk) begin
        if (ps === 1'b1) starts++;
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // Little mode address fix for an operand size
    function automatic logic [2:0] fix(int n);
        return big ? 3'h0 : n == 1 ? 3'h7 : n == 2 ? 3'h6 : n == 4 ? 3'h4 : 3'h0;
    endfunction
    function automatic logic [63:0] swp(logic [63:0] v);
        for (int i = 0; i < 8; i++) swp[8*i+:8] = v[56-8*i+:8];
    endfunction
    // Configuration address phase for a pointer value
    function automatic logic [31:0] cfg(logic [31:0] q);
        logic [31:0] sel;
        sel = q[15:11] == 5'h00 ? 32'h8000_0000 : q[15:11] > 5'h0A ? 32'h1 << q[15:11] : 32'h0;
        if (q[15:11] == 5'h1F) sel = 32'h0;
        return q[23:16] != 8'h00 ? {8'h00, q[23:2], 2'b01} : sel | {21'h0, q[10:2], 2'b00};
    endfunction
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One access; k above 0 expects one launch, below 0 a miss; k of 2 leaves the address unchecked
    task automatic acc(logic w, logic [31:0] ad, int n, logic [63:0] d, int k,
                       logic [3:0] c, logic [31:0] e);
        int b;
        b = starts;
        @(negedge clk);
        {rv, rw, ra, rs, rwd, pw, pat} = {1'b1, w, ad, 4'(n), d, 4'(rnd() % 6), rnd(), rnd()};
        @(negedge clk);
        rv = 0;
        for (int j = 0; j < 300 && rsv !== 1'b1; j++) @(negedge clk);
        chk("answer", 64'h1, 64'(rsv));
        chk("launches", 64'(k > 0), 64'(starts - b));
        chk("miss", 64'(k < 0), 64'(miss));
        if (k > 0) begin
            chk("command", 64'(c), 64'(pc));
            if (k == 1) chk("address", 64'(e), 64'(pa));
            chk("data", big ? swp(w ? d : pat) : w ? d : pat, w ? pwd : rd);
        end
    endtask
    task automatic win(logic [1:0] i, logic m, logic o, logic [15:0] st, logic [15:0] of);
        @(negedge clk);
        {wl, wx, wm, wi, wst, wo} = {1'b1, i, m, o, st, of};
        @(negedge clk);
        wl = 0;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        // Configuration cycles over device and bus numbers
        for (int i = 0; i < 8; i++) begin
            p = {8'h80, i == 7 ? 8'(rnd()) | 8'h01 : 8'h00, 16'(rnd()) | 16'h0004};
            if (i < 6) p[15:11] = dv[i];
            acc(1, 32'h8000_0CFC, 4, {p, p}, 0, 4'h0, 32'h0);
            acc(i[0], 32'h8000_0CF8, 4, {2{rnd()}}, 1, {3'h5, i[0]}, cfg(p));
        end
        acc(1, 32'h8000_0CFC, 4, 64'h0, 0, 4'h0, 32'h0);
        acc(0, 32'h8000_0CF8, 4, 64'h0, 1, 4'h2, 32'h0000_0CFC);
        acc(0, 32'h8000_0CF8, 8, 64'h0, 1, 4'h2, 32'h0000_0CF8);
        acc(1, 32'h8000_0CFC, 4, {2{32'h8000_FF00}}, 0, 4'h0, 32'h0);
        acc(1, 32'h8000_0CF8, 4, {2{rnd()}}, 2, 4'h1, 32'h0);
        acc(0, 32'hFEFF_0030, 4, 64'h0, 2, 4'h0, 32'h0);
        acc(0, 32'h0, 4, 64'h0, -1, 4'h0, 32'h0);
        for (int n = 1; n <= 8; n *= 2) acc(0, 32'h8000_1000, n, 64'h0, 1, 4'h2, {29'h200, fix(n)});
        win(2'h0, 1, 0, 16'h1234, 16'h2000);
        win(2'h1, 0, 1, 16'h4000, 16'h0100);
        for (int b = 0; b < 2; b++) begin
            big = b[0];
            acc(1, 32'h1234_5670, 8, {rnd(), rnd()}, 1, 4'h7, 32'h3234_5670);
            acc(0, 32'h1234_5670, 8, 64'h0, 1, 4'h6, 32'h3234_5670);
            acc(0, 32'h4000_3008, 8, 64'h0, 1, 4'h2, 32'h0082_0068);
        end
        // Aligned pieces of PCI-side transfers, with random stalls
        for (int t = 0; t < 6; t++) begin
            {big, a, l} = {t[0], t ? rnd() : 32'h3, t ? 32'(rnd() % 8 + 1) : 32'h6};
            @(negedge clk);
            {iv, ia, il} = {1'b1, a, 4'(l)};
            @(negedge clk);
            iv = 0;
            while (l > 0) begin
                sr = rnd() > 32'h8000_0000;
                s = l >= 8 && a % 8 == 0 ? 8 : l >= 4 && a % 4 == 0 ? 4 : l >= 2 && a % 2 == 0 ? 2 : 1;
                if (sr && sv === 1'b1) begin
                    chk("piece address", 64'({a[31:3], a[2:0] ^ fix(s)}), 64'(sa));
                    chk("piece size", 64'(s), 64'(ss));
                    {a, l} = {a + 32'(s), l - s};
                end
                @(negedge clk);
            end
            sr = 0;
        end
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- verif/hpc_pci_tgt.sv ----
// PCI target model answering each launched cycle after a set wait
`timescale 1ns/1ps
`default_nettype none
module hpc_pci_tgt (
    input  wire logic        clk_i,   // Bridge clock
    input  wire logic        rst_n_i, // Reset, low
    input  wire logic        start_i, // Cycle launch
    input  wire logic [3:0]  wait_i,  // Wait cycles
    input  wire logic [63:0] pat_i,   // Data to return
    output logic             done_o,  // Completion pulse
    output logic      [63:0] data_o   // Read data
);
    logic [4:0] cnt_q; // Bit 4 marks a cycle in flight
    // Count down, answer one cycle, scramble data lines otherwise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {cnt_q, done_o, data_o} <= '0;
        end else begin
            done_o <= cnt_q == 5'h10;
            data_o <= cnt_q == 5'h10 ? pat_i : ~data_o;
            cnt_q  <= start_i ? {1'b1, wait_i} : cnt_q[4] ? cnt_q - 5'h01 : 5'h00;
        end
    end
endmodule
`default_nettype wire
